// *** hw/uies_consts.svh ***
`ifndef UIES_CONSTS_SVH
`define UIES_CONSTS_SVH

// register offsets on the A2-A0 port
`define UIES_A_DATA      3'h0
`define UIES_A_IER       3'h1
`define UIES_A_ISR       3'h2
`define UIES_A_LCR       3'h3
`define UIES_A_MCR       3'h4
`define UIES_A_LSR       3'h5
`define UIES_A_MSR       3'h6
`define UIES_A_SPR       3'h7
`define UIES_A_DLM       3'h1
`define UIES_A_EFR       3'h2
`define UIES_A_FLOW_ON_CHAR_1      3'h4
`define UIES_A_FLOW_ON_CHAR_2      3'h5
`define UIES_A_FLOW_OFF_CHAR_1     3'h6
`define UIES_A_FLOW_OFF_CHAR_2     3'h7

// line control value that opens the enhanced group
`define UIES_LCR_ENH     8'hbf
`define UIES_LCR_DIV     7
`define UIES_EFR_GATE    4
`define UIES_FCR_EN      0
`define UIES_FCR_RXRST   1
`define UIES_FCR_TXRST   2

// bits that the extended-bit gate guards
`define UIES_IER_GMASK   8'hf0
`define UIES_ISR_GMASK   8'h30
`define UIES_FCR_GMASK   8'h30
`define UIES_MCR_GMASK   8'he4

`define UIES_RST_BYTE    8'h00
`define UIES_RST_DIV     16'h0000

// interrupt status codes
`define UIES_ISR_NONE    6'h01
`define UIES_ISR_LINE    6'h06
`define UIES_ISR_RXRDY   6'h04
`define UIES_ISR_TXRDY   6'h02
`define UIES_ISR_MODEM   6'h00
`define UIES_ISR_XOFF    6'h10
`define UIES_ISR_FLOW    6'h20

// fifo trigger levels for selector 00..11
`define UIES_TRIG0       5'd1
`define UIES_TRIG1       5'd4
`define UIES_TRIG2       5'd8
`define UIES_TRIG3       5'd14
`define UIES_RX_DEPTH    5'd16

`endif

// *** hw/uies_pkg.sv ***
`default_nettype none
package uies_pkg;
   typedef logic [7:0] uies_byte_t;
   typedef logic [2:0] uies_addr_t;
   typedef enum logic [2:0] {
      SRC_NONE, SRC_LINE, SRC_RXRDY, SRC_TXRDY, SRC_MODEM, SRC_XOFF, SRC_FLOW
   } uies_src_e;
endpackage : uies_pkg
`default_nettype wire

// *** hw/uies_ctrl.sv ***
// Notes on behaviour
// - enhanced feature bit 4 unlocks the extended mask, status, fifo, modem bits
// - baud generator is a 16-bit counter loaded from the divisor pair
// - divisor registers are reachable only while line control bit 7 is set
// - fifo mode: receive interrupt while fill level is at or above trigger
// - status code drops below the trigger; interrupt output drops one clock later
// - data ready sets on a character entering the fifo, clears when empty
// - line status bit 1 flags a receive overrun
// - line status bits 2 to 4 show errors of the head character
// - bit 5 is holding empty; bit 6 needs holding and shift both empty
// - bit 7 is set while any stored character carries an error
// - mask bit 0 enables receive data interrupt; resets to zero
// - mask bit 1 enables transmit ready interrupt; resets to zero
// - enabling transmit interrupt with holding empty interrupts at once
// - mask bit 2 raises line interrupt when status bits 1 to 4 set
// - overrun interrupts at once; other errors when character reaches head
// - mask bit 3 enables the modem status interrupt; resets to zero
// - mask bit 4 is sleep enable, gated, resets to zero
// - mask bit 5 enables flow-off character interrupt, gated, resets zero
// - mask bit 6 interrupts on request-to-send rising, gated, resets zero
`timescale 1ns/1ps
`default_nettype none
`include "uies_consts.svh"
module uies_ctrl (
   // clock and reset
   input  wire logic               clk_i,
   input  wire logic               nrst_i,
   // host register port
   input  wire logic               cs_i,
   input  wire logic               rd_i,
   input  wire logic               wr_i,
   input  wire uies_pkg::uies_addr_t addr_i,
   input  wire uies_pkg::uies_byte_t wdata_i,
   output var  uies_pkg::uies_byte_t rdata_o,
   // receiver side
   input  wire logic               rx_push_i,
   input  wire uies_pkg::uies_byte_t rx_char_i,
   input  wire logic               rx_perr_i,
   input  wire logic               rx_ferr_i,
   input  wire logic               rx_brk_i,
   // transmitter side
   output var  uies_pkg::uies_byte_t tx_data_o,
   output logic                    tx_valid_o,
   input  wire logic               tx_ready_i,
   input  wire logic               tx_shift_empty_i,
   // modem and flow control
   input  wire uies_pkg::uies_byte_t msr_i,
   input  wire logic               modem_int_i,
   input  wire logic               cts_i,
   input  wire logic               xoff_det_i,
   output logic                    rts_o,
   output logic                    sleep_en_o,
   output var  uies_pkg::uies_byte_t efr_o,
   output var  uies_pkg::uies_byte_t flow_on1_o,
   output var  uies_pkg::uies_byte_t flow_on2_o,
   output var  uies_pkg::uies_byte_t flow_off1_o,
   output var  uies_pkg::uies_byte_t flow_off2_o,
   // status outputs
   output logic                    irq_o,
   output logic                    baud_tick_o
);
   import uies_pkg::*;

   function automatic uies_byte_t gate_f(input uies_byte_t v,
                                         input uies_byte_t m,
                                         input logic       open);
      gate_f = open ? v : (v & ~m);
   endfunction : gate_f

   function automatic uies_byte_t merge_f(input uies_byte_t old_v,
                                          input uies_byte_t new_v,
                                          input uies_byte_t m,
                                          input logic       open);
      merge_f = open ? new_v : ((new_v & ~m) | (old_v & m));
   endfunction : merge_f

   function automatic logic [4:0] trig_f(input logic [1:0] s);
      unique case (s)
         2'h0: trig_f = `UIES_TRIG0;
         2'h1: trig_f = `UIES_TRIG1;
         2'h2: trig_f = `UIES_TRIG2;
         2'h3: trig_f = `UIES_TRIG3;
      endcase
   endfunction : trig_f

   function automatic logic [5:0] code_f(input uies_src_e s);
      unique case (s)
         SRC_LINE:  code_f = `UIES_ISR_LINE;
         SRC_RXRDY: code_f = `UIES_ISR_RXRDY;
         SRC_TXRDY: code_f = `UIES_ISR_TXRDY;
         SRC_MODEM: code_f = `UIES_ISR_MODEM;
         SRC_XOFF:  code_f = `UIES_ISR_XOFF;
         SRC_FLOW:  code_f = `UIES_ISR_FLOW;
         default:   code_f = `UIES_ISR_NONE;
      endcase
   endfunction : code_f

   uies_byte_t  lcr_r, ier_r, fcr_r, mcr_r, spr_r, efr_r, dll_r, dlm_r;
   uies_byte_t  flow_on_char_1_r, flow_on_char_2_r, flow_off_char_1_r, flow_off_char_2_r;
   logic [10:0] rx_mem [16];
   logic [3:0]  rx_wp_r, rx_rp_r;
   logic [4:0]  rx_cnt_r, rx_ecnt_r;
   logic        ovr_r, thr_int_r, xoff_r, flow_r, below_r;
   logic        cts_d_r, rts_d_r;
   uies_byte_t  tx_d1_r;
   logic        tx_v1_r;
   logic [15:0] bcnt_r;

   // access decode
   wire        rd_w     = cs_i & rd_i;
   wire        wr_w     = cs_i & wr_i;
   wire        gate_w   = efr_r[`UIES_EFR_GATE];
   wire        dl_w     = lcr_r[`UIES_LCR_DIV];
   wire        enh_w    = (lcr_r == `UIES_LCR_ENH);
   wire        a_dat_w  = (addr_i == `UIES_A_DATA);
   wire        a_ier_w  = (addr_i == `UIES_A_IER);
   wire        a_isr_w  = (addr_i == `UIES_A_ISR);
   wire        a_mcr_w  = (addr_i == `UIES_A_MCR);
   wire        sel_dll_w = dl_w & a_dat_w;
   wire        sel_dlm_w = dl_w & (addr_i == `UIES_A_DLM);
   wire        sel_hold_w = ~dl_w & a_dat_w;
   wire        sel_ier_w = ~dl_w & a_ier_w;
   wire        sel_isr_w = ~enh_w & a_isr_w;
   wire        sel_efr_w = enh_w & (addr_i == `UIES_A_EFR);
   wire        sel_mcr_w = ~enh_w & a_mcr_w;
   wire        sel_lsr_w = ~enh_w & (addr_i == `UIES_A_LSR);
   wire        sel_msr_w = ~enh_w & (addr_i == `UIES_A_MSR);
   wire        sel_spr_w = ~enh_w & (addr_i == `UIES_A_SPR);
   wire        fcr_wr_w = wr_w & sel_isr_w & wdata_i[`UIES_FCR_EN];
   wire        fcr_on_w = fcr_r[`UIES_FCR_EN];
   wire        rx_rst_w = fcr_wr_w & wdata_i[`UIES_FCR_RXRST];
   wire        tx_rst_w = fcr_wr_w & wdata_i[`UIES_FCR_TXRST];
   wire        isr_rd_w = rd_w & sel_isr_w;
   wire        msr_rd_w = rd_w & sel_msr_w;
   wire uies_byte_t ier_eff_w = gate_f(ier_r, `UIES_IER_GMASK, gate_w);

   // receive fifo
   wire [4:0]  rx_cap_w  = fcr_on_w ? `UIES_RX_DEPTH : 5'd1;
   wire        rx_full_w = (rx_cnt_r >= rx_cap_w);
   wire        rx_nemp_w = (rx_cnt_r != 5'd0);
   wire        rx_push_w = rx_push_i & ~rx_full_w;
   wire        rx_ovr_w  = rx_push_i & rx_full_w;
   wire        rx_pop_w  = rd_w & sel_hold_w & rx_nemp_w;
   wire [10:0] rx_head_w = rx_mem[rx_rp_r];
   wire        push_err_w = rx_push_w & (rx_perr_i | rx_ferr_i | rx_brk_i);
   wire        pop_err_w  = rx_pop_w & (|rx_head_w[10:8]);
   wire [4:0]  rx_trig_w  = trig_f(fcr_r[7:6]);

   // transmit two-entry buffer
   wire        tx_pop_w  = tx_valid_o & tx_ready_i;
   wire        tx_push_w = wr_w & sel_hold_w & ~tx_v1_r;
   wire [4:0]  tx_cnt_w  = {3'h0, tx_valid_o} + {4'h0, tx_v1_r};
   wire [4:0]  tx_thr_w  = fcr_on_w ? trig_f(fcr_r[5:4]) : 5'd1;
   wire        below_w   = (tx_cnt_w < tx_thr_w);
   wire        ier_tx_on_w = wr_w & sel_ier_w & wdata_i[1] & ~ier_r[1];

   // line status
   wire uies_byte_t lsr_w = {
      rx_ecnt_r != 5'd0,
      ~tx_valid_o & tx_shift_empty_i,
      ~tx_valid_o,
      rx_nemp_w ? rx_head_w[10:8] : 3'h0,
      ovr_r,
      rx_nemp_w };

   // interrupt sources in priority order
   wire        line_int_w = ier_eff_w[2] & (|lsr_w[4:1]);
   wire        rxd_int_w  = ier_eff_w[0] &
                            (fcr_on_w ? (rx_cnt_r >= rx_trig_w)
                                      : rx_nemp_w);
   wire        txd_int_w  = ier_eff_w[1] & thr_int_r;
   wire        mdm_int_w  = ier_eff_w[3] & modem_int_i;
   wire        xof_int_w  = ier_eff_w[5] & xoff_r;
   wire        flw_int_w  = flow_r;
   wire uies_src_e src_w  = line_int_w ? SRC_LINE  :
                            rxd_int_w  ? SRC_RXRDY :
                            txd_int_w  ? SRC_TXRDY :
                            mdm_int_w  ? SRC_MODEM :
                            xof_int_w  ? SRC_XOFF  :
                            flw_int_w  ? SRC_FLOW  : SRC_NONE;
   wire uies_byte_t isr_w = gate_f({fcr_on_w, fcr_on_w, code_f(src_w)},
                                   `UIES_ISR_GMASK, gate_w);
   wire        rts_rise_w = mcr_r[1] & ~rts_d_r;
   wire        cts_rise_w = cts_i & ~cts_d_r;
   wire        flow_set_w = (ier_eff_w[6] & rts_rise_w) |
                            (ier_eff_w[7] & cts_rise_w);

   // read data selection
   wire uies_byte_t rd_mux_w =
      sel_dll_w  ? dll_r :
      sel_dlm_w  ? dlm_r :
      sel_hold_w ? (rx_nemp_w ? rx_head_w[7:0] : 8'h00) :
      sel_ier_w  ? ier_eff_w :
      sel_efr_w  ? efr_r :
      sel_isr_w  ? isr_w :
      (addr_i == `UIES_A_LCR) ? lcr_r :
      sel_mcr_w  ? gate_f(mcr_r, `UIES_MCR_GMASK, gate_w) :
      sel_lsr_w  ? lsr_w :
      sel_msr_w  ? msr_i :
      sel_spr_w  ? spr_r : 8'h00;

   wire [15:0] div_w = {dlm_r, dll_r};

   // host-writable registers
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         lcr_r <= `UIES_RST_BYTE; ier_r <= `UIES_RST_BYTE;
         fcr_r <= `UIES_RST_BYTE; mcr_r <= `UIES_RST_BYTE;
         spr_r <= `UIES_RST_BYTE; efr_r <= `UIES_RST_BYTE;
         dll_r <= `UIES_RST_BYTE; dlm_r <= `UIES_RST_BYTE;
         flow_on_char_1_r <= `UIES_RST_BYTE; flow_on_char_2_r <= `UIES_RST_BYTE;
         flow_off_char_1_r <= `UIES_RST_BYTE; flow_off_char_2_r <= `UIES_RST_BYTE;
      end
      else if (wr_w)
      begin
         if (addr_i == `UIES_A_LCR) lcr_r <= wdata_i;
         if (sel_dll_w) dll_r <= wdata_i;
         if (sel_dlm_w) dlm_r <= wdata_i;
         if (sel_ier_w)
            ier_r <= merge_f(ier_r, wdata_i, `UIES_IER_GMASK,
                             gate_w);
         if (fcr_wr_w)
            fcr_r <= merge_f(fcr_r, wdata_i & 8'hf1, `UIES_FCR_GMASK,
                             gate_w);
         else if (sel_isr_w)
            fcr_r[`UIES_FCR_EN] <= 1'b0;
         if (sel_mcr_w)
            mcr_r <= merge_f(mcr_r, wdata_i, `UIES_MCR_GMASK, gate_w);
         if (sel_spr_w) spr_r <= wdata_i;
         if (sel_efr_w) efr_r <= wdata_i;
         if (enh_w && addr_i == `UIES_A_FLOW_ON_CHAR_1) flow_on_char_1_r <= wdata_i;
         if (enh_w && addr_i == `UIES_A_FLOW_ON_CHAR_2) flow_on_char_2_r <= wdata_i;
         if (enh_w && addr_i == `UIES_A_FLOW_OFF_CHAR_1) flow_off_char_1_r <= wdata_i;
         if (enh_w && addr_i == `UIES_A_FLOW_OFF_CHAR_2) flow_off_char_2_r <= wdata_i;
      end
   end

   // receive fifo storage
   always_ff @(posedge clk_i)
   begin
      if (rx_push_w)
         rx_mem[rx_wp_r] <= {rx_brk_i, rx_ferr_i, rx_perr_i, rx_char_i};
   end

   // receive fifo pointers and counts
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rx_wp_r <= 4'h0; rx_rp_r <= 4'h0;
         rx_cnt_r <= 5'h00; rx_ecnt_r <= 5'h00;
      end
      else if (rx_rst_w)
      begin
         rx_wp_r <= 4'h0; rx_rp_r <= 4'h0;
         rx_cnt_r <= 5'h00; rx_ecnt_r <= 5'h00;
      end
      else
      begin
         rx_wp_r   <= rx_wp_r + {3'h0, rx_push_w};
         rx_rp_r   <= rx_rp_r + {3'h0, rx_pop_w};
         rx_cnt_r  <= rx_cnt_r + {4'h0, rx_push_w} - {4'h0, rx_pop_w};
         rx_ecnt_r <= rx_ecnt_r + {4'h0, push_err_w}
                      - {4'h0, pop_err_w};
      end
   end

   // transmit buffer, head slot drives the port
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         tx_valid_o <= 1'b0; tx_v1_r <= 1'b0;
         tx_data_o  <= `UIES_RST_BYTE; tx_d1_r <= `UIES_RST_BYTE;
      end
      else if (tx_rst_w)
      begin
         tx_valid_o <= 1'b0; tx_v1_r <= 1'b0;
      end
      else if (tx_pop_w)
      begin
         tx_valid_o <= tx_v1_r | tx_push_w;
         tx_v1_r    <= tx_v1_r & tx_push_w;
         if (tx_v1_r) tx_data_o <= tx_d1_r;
         else if (tx_push_w) tx_data_o <= wdata_i;
         if (tx_v1_r && tx_push_w) tx_d1_r <= wdata_i;
      end
      else if (tx_push_w)
      begin
         if (!tx_valid_o)
         begin
            tx_valid_o <= 1'b1; tx_data_o <= wdata_i;
         end
         else
         begin
            tx_v1_r <= 1'b1; tx_d1_r <= wdata_i;
         end
      end
   end

   // sticky interrupt flags, a set beats a clear in the same cycle
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         ovr_r <= 1'b0; thr_int_r <= 1'b0; xoff_r <= 1'b0;
         flow_r <= 1'b0; below_r <= 1'b1;
         cts_d_r <= 1'b0; rts_d_r <= 1'b0;
      end
      else
      begin
         below_r <= below_w;
         cts_d_r <= cts_i;
         rts_d_r <= mcr_r[1];
         ovr_r   <= rx_ovr_w | (ovr_r & ~(rd_w & sel_lsr_w));
         thr_int_r <= (below_w & ~below_r) | (ier_tx_on_w & below_w) |
                      (thr_int_r & ~(wr_w & sel_hold_w) &
                       ~(isr_rd_w && src_w == SRC_TXRDY));
         xoff_r <= xoff_det_i | (xoff_r & ~isr_rd_w);
         flow_r <= flow_set_w | (flow_r & ~msr_rd_w);
      end
   end

   // baud generator
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         bcnt_r <= `UIES_RST_DIV; baud_tick_o <= 1'b0;
      end
      else if (div_w == 16'h0000)
      begin
         bcnt_r <= `UIES_RST_DIV; baud_tick_o <= 1'b0;
      end
      else
      begin
         baud_tick_o <= (bcnt_r == 16'h0000);
         bcnt_r <= (bcnt_r == 16'h0000) ? div_w - 16'h0001
                                        : bcnt_r - 16'h0001;
      end
   end

   // registered outputs
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rdata_o <= `UIES_RST_BYTE; irq_o <= 1'b0; rts_o <= 1'b0;
         sleep_en_o <= 1'b0; efr_o <= `UIES_RST_BYTE;
         flow_on1_o <= `UIES_RST_BYTE; flow_on2_o <= `UIES_RST_BYTE;
         flow_off1_o <= `UIES_RST_BYTE; flow_off2_o <= `UIES_RST_BYTE;
      end
      else
      begin
         if (rd_w) rdata_o <= rd_mux_w;
         irq_o       <= (src_w != SRC_NONE);
         rts_o       <= mcr_r[1];
         sleep_en_o  <= ier_eff_w[4];
         efr_o       <= efr_r;
         flow_on1_o  <= flow_on_char_1_r;  flow_on2_o  <= flow_on_char_2_r;
         flow_off1_o <= flow_off_char_1_r; flow_off2_o <= flow_off_char_2_r;
      end
   end

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   sequence s_tx_enable;
      ier_tx_on_w && below_w;
   endsequence
   sequence s_quiet_bus;
      !(cs_i && (rd_i || wr_i));
   endsequence

   a_gate_ier_read: assert property (
      (rd_w && sel_ier_w && !gate_w) |=> rdata_o[7:4] == 4'h0)
      else $error("gated mask bits read nonzero");
   a_divisor_locked: assert property (
      (wr_w && a_dat_w && !dl_w) |=> dll_r == $past(dll_r))
      else $error("divisor low changed without access bit");
   a_baud_reload: assert property (
      (bcnt_r == 16'h0000 && div_w != 16'h0000) |=>
         baud_tick_o && bcnt_r == $past(div_w) - 16'h0001)
      else $error("baud counter did not reload on terminal count");
   a_rx_trigger_irq: assert property (
      (fcr_on_w && ier_eff_w[0] && rx_cnt_r >= rx_trig_w) |=> irq_o)
      else $error("receive trigger reached without interrupt");
   a_data_ready: assert property (
      (rx_push_w && !rx_rst_w) |=> lsr_w[0])
      else $error("data ready not set after push");
   a_overrun_flag: assert property (
      rx_ovr_w |=> ovr_r)
      else $error("overrun not flagged");
   a_temt_needs_thre: assert property (
      lsr_w[6] |-> lsr_w[5])
      else $error("shift empty shown with holding full");
   a_global_error: assert property (
      lsr_w[7] |-> rx_nemp_w)
      else $error("global error with empty fifo");
   a_tx_enable_irq: assert property (
      (s_tx_enable ##1 s_quiet_bus) |=> irq_o)
      else $error("no transmit interrupt on enable while empty");
   a_line_irq: assert property (
      (ier_eff_w[2] && lsr_w[4:1] != 4'h0) |=> irq_o)
      else $error("line status interrupt missing");
   a_rts_rise_irq: assert property (
      (rts_rise_w && ier_eff_w[6] ##1 !msr_rd_w) |=> irq_o)
      else $error("request-to-send rise gave no interrupt");

endmodule : uies_ctrl
`default_nettype wire

// *** test/uies_tx_sink.sv ***
`timescale 1ns/1ps
`default_nettype none
module uies_tx_sink #(
   parameter int SHIFT_CYCLES = 8
) (
   // clock, reset and test control
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   input  wire logic       stall_i,
   // transmit buffer side
   input  wire logic       valid_i,
   input  wire logic [7:0] data_i,
   output logic            ready_o,
   output logic            empty_o,
   // log of taken words
   output logic [7:0]      last_o,
   output logic [7:0]      count_o
);
   logic [7:0] busy_r;
   // shift register stays busy for a whole character
   assign empty_o = (busy_r == 8'h00);
   assign ready_o = !stall_i && empty_o;
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         busy_r  <= 8'h00;
         last_o  <= 8'h00;
         count_o <= 8'h00;
      end
      else if (valid_i && ready_o)
      begin
         busy_r  <= 8'(SHIFT_CYCLES);
         last_o  <= data_i;
         count_o <= count_o + 8'h01;
      end
      else if (!empty_o)
      begin
         busy_r <= busy_r - 8'h01;
      end
   end
endmodule : uies_tx_sink
`default_nettype wire

// *** test/uies_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module uies_tb_top;
   import uies_pkg::*;
   typedef struct packed {
      uies_byte_t line_control;
      uies_addr_t a;
      uies_byte_t d;
      uies_byte_t e;
   } uies_row_s;
   logic       clk_i = 1'b0, nrst_i = 1'b0, stall = 1'b1;
   logic       cs_i = 1'b0, rd_i = 1'b0, wr_i = 1'b0;
   logic       rx_push_i = 1'b0, rx_perr_i = 1'b0;
   logic       rx_ferr_i = 1'b0, rx_brk_i = 1'b0, rts_b;
   logic       modem_int_i = 1'b0, xoff_det_i = 1'b0;
   uies_addr_t addr_i = 3'h0;
   uies_byte_t wdata_i = 8'h00, rx_char_i = 8'h00;
   logic       tx_valid_o, tx_ready_i, tx_empty, sleep_en_o, irq_o, baud_tick_o;
   uies_byte_t rdata_o, tx_data_o, on1_o, last_b, n_taken, v;
   uies_byte_t efr_b, on2_o, off1_o, off2_o;
   int         n_errors = 0, checks = 0, cyc = 0, n;
   uies_row_s  rows [10] = '{
      '{8'h00, 3'h1, 8'hff, 8'h0f},
      '{8'hbf, 3'h2, 8'h10, 8'h10},
      '{8'h00, 3'h1, 8'hf0, 8'hf0},
      '{8'hbf, 3'h4, 8'haa, 8'h00},
      '{8'hbf, 3'h5, 8'hbb, 8'h00},
      '{8'hbf, 3'h6, 8'hcc, 8'h00},
      '{8'hbf, 3'h7, 8'hdd, 8'h00},
      '{8'h80, 3'h0, 8'h05, 8'h05},
      '{8'h80, 3'h1, 8'h00, 8'h00},
      '{8'h00, 3'h1, 8'h00, 8'h00}};

   uies_ctrl DUT (
      .clk_i(clk_i), .nrst_i(nrst_i), .cs_i(cs_i), .rd_i(rd_i), .wr_i(wr_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
      .rx_push_i(rx_push_i), .rx_char_i(rx_char_i), .rx_perr_i(rx_perr_i),
      .rx_ferr_i(rx_ferr_i), .rx_brk_i(rx_brk_i), .tx_data_o(tx_data_o),
      .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
      .tx_shift_empty_i(tx_empty), .msr_i(8'h00), .modem_int_i(modem_int_i),
      .cts_i(1'b0), .xoff_det_i(xoff_det_i), .rts_o(rts_b),
      .sleep_en_o(sleep_en_o), .efr_o(efr_b), .flow_on1_o(on1_o),
      .flow_on2_o(on2_o), .flow_off1_o(off1_o), .flow_off2_o(off2_o),
      .irq_o(irq_o), .baud_tick_o(baud_tick_o));

   uies_tx_sink SINK (
      .clk_i(clk_i), .nrst_i(nrst_i), .stall_i(stall), .valid_i(tx_valid_o),
      .data_i(tx_data_o), .ready_o(tx_ready_i), .empty_o(tx_empty),
      .last_o(last_b), .count_o(n_taken));

   task automatic chk(input uies_byte_t got, input uies_byte_t exp);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("ERROR at %0t ns: saw %h, wanted %h", $time, got, exp);
      end
   endtask : chk

   task automatic bus(input logic w, input uies_addr_t a,
                      input uies_byte_t d);
      @(posedge clk_i);
      cs_i <= 1'b1;
      wr_i <= w;
      rd_i <= !w;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      cs_i <= 1'b0;
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      #1;
      v = rdata_o;
   endtask : bus

   task automatic rdc(input uies_addr_t a, input uies_byte_t e);
      bus(1'b0, a, 8'h00);
      chk(v, e);
   endtask : rdc

   task automatic push(input uies_byte_t c, input logic p);
      @(posedge clk_i);
      rx_push_i <= 1'b1;
      rx_char_i <= c;
      rx_perr_i <= p;
      @(posedge clk_i);
      rx_push_i <= 1'b0;
   endtask : push

   task automatic irq_is(input logic e);
      repeat (4) @(posedge clk_i);
      #1;
      chk({7'h00, irq_o}, {7'h00, e});
   endtask : irq_is

   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
      begin
         $display("RESULT: PASS");
      end
      else
      begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   initial
   begin
      forever #12.5 clk_i = ~clk_i;
   end

   // hang guard, far above the length of the run
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         n_errors++;
         tally_and_finish();
      end
   end

   initial
   begin
      repeat (20) @(posedge clk_i);
      nrst_i <= 1'b1;
      rdc(3'h5, 8'h60);
      rdc(3'h1, 8'h00);
      foreach (rows[i])
      begin
         bus(1'b1, 3'h3, rows[i].line_control);
         bus(1'b1, rows[i].a, rows[i].d);
         rdc(rows[i].a, rows[i].e);
      end
      chk(on1_o, 8'haa);
      chk(on2_o, 8'hbb);
      chk(off1_o, 8'hcc);
      chk(off2_o, 8'hdd);
      chk(efr_b, 8'h10);
      // divisor 5 gives ten ticks in any fifty cycles
      n = 0;
      repeat (50)
      begin
         @(posedge clk_i);
         #1;
         n += baud_tick_o;
      end
      chk(8'(n), 8'h0a);
      bus(1'b1, 3'h2, 8'h41);
      bus(1'b1, 3'h1, 8'h01);
      for (int k = 0; k < 3; k++)
      begin
         push(8'(8'h10 + k), 1'b0);
      end
      rdc(3'h5, 8'h61);
      irq_is(1'b0);
      push(8'h13, 1'b0);
      irq_is(1'b1);
      rdc(3'h2, 8'hc4);
      rdc(3'h0, 8'h10);
      irq_is(1'b0);
      rdc(3'h2, 8'hc1);
      for (int k = 1; k < 4; k++)
      begin
         rdc(3'h0, 8'(8'h10 + k));
      end
      rdc(3'h5, 8'h60);
      bus(1'b1, 3'h1, 8'h04);
      push(8'h5e, 1'b1);
      irq_is(1'b1);
      rdc(3'h5, 8'he5);
      rdc(3'h0, 8'h5e);
      rdc(3'h5, 8'h60);
      irq_is(1'b0);
      @(posedge clk_i);
      rx_ferr_i <= 1'b1;
      rx_brk_i <= 1'b1;
      push(8'h7e, 1'b0);
      rx_ferr_i <= 1'b0;
      rx_brk_i <= 1'b0;
      rdc(3'h5, 8'hf9);
      rdc(3'h0, 8'h7e);
      rdc(3'h5, 8'h60);
      bus(1'b1, 3'h2, 8'h00);
      push(8'h01, 1'b0);
      push(8'h02, 1'b0);
      irq_is(1'b1);
      rdc(3'h5, 8'h63);
      rdc(3'h5, 8'h61);
      irq_is(1'b0);
      rdc(3'h0, 8'h01);
      bus(1'b1, 3'h1, 8'h02);
      irq_is(1'b1);
      rdc(3'h2, 8'h02);
      irq_is(1'b0);
      bus(1'b1, 3'h0, 8'ha1);
      bus(1'b1, 3'h0, 8'ha2);
      bus(1'b1, 3'h0, 8'ha3);
      rdc(3'h5, 8'h00);
      @(posedge clk_i);
      stall <= 1'b0;
      n = 0;
      while (tx_valid_o !== 1'b0 && n < 60)
      begin
         @(posedge clk_i);
         #1;
         n++;
      end
      rdc(3'h5, 8'h20);
      irq_is(1'b1);
      repeat (10) @(posedge clk_i);
      rdc(3'h5, 8'h60);
      chk(n_taken, 8'h02);
      chk(last_b, 8'ha2);
      rdc(3'h2, 8'h02);
      bus(1'b1, 3'h1, 8'h70);
      @(posedge clk_i);
      #1;
      chk({7'h00, sleep_en_o}, 8'h01);
      bus(1'b1, 3'h4, 8'h02);
      irq_is(1'b1);
      chk({7'h00, rts_b}, 8'h01);
      rdc(3'h2, 8'h20);
      rdc(3'h6, 8'h00);
      irq_is(1'b0);
      @(posedge clk_i);
      xoff_det_i <= 1'b1;
      @(posedge clk_i);
      xoff_det_i <= 1'b0;
      irq_is(1'b1);
      rdc(3'h2, 8'h10);
      irq_is(1'b0);
      bus(1'b1, 3'h1, 8'h08);
      @(posedge clk_i);
      modem_int_i <= 1'b1;
      irq_is(1'b1);
      rdc(3'h2, 8'h00);
      @(posedge clk_i);
      modem_int_i <= 1'b0;
      bus(1'b1, 3'h3, 8'hbf);
      bus(1'b1, 3'h2, 8'h00);
      bus(1'b1, 3'h3, 8'h00);
      bus(1'b1, 3'h1, 8'hf8);
      rdc(3'h1, 8'h08);
      chk({7'h00, sleep_en_o}, 8'h00);
      tally_and_finish();
   end
endmodule : uies_tb_top
`default_nettype wire
